// ---- hw/mpo_output_stage.sv ----
// Motor PWM output stage: saturation, pairing, dead time and pair selection
//
// Behaviour
// - Duty registers are 16-bit signed, compared against a 12-bit counter.
// - Zero or negative duty keeps the channel inactive all period.
// - Duty at or above modulus keeps the channel active all period.
// - 0000-0fff used as is, 1000-7fff clamp to fff, 8000-ffff clamp to 000.
// - A control bit picks six separate channels or three complementary pairs.
// - Complementary pair outputs both come from one selected duty register.
// - Separate mode drives each output from its own duty register.
// - Dead time and top/bottom selection act only in complementary mode.
// - Dead interval is an 8-bit count of clock cycles.
// - Dead interval ignores the prescaler and PWM period.
// - Dead-time input is top generator output, or odd manual bit when manual.
// - Any dead-time input transition forces both pair outputs inactive.
// - Bottom output derives from top and dead time; never both active.
// - Manual complementary: even bits gate bottom relative to odd bits.
// - Sensed current picks which pair duty drives the next period.
// - Sense or polarity low selects the odd (top) duty register.
// - Sense or polarity high selects the even (bottom) duty register.
// - Outputs 1,3,5 top, 2,4,6 bottom; selector n picks register 2n-1 or 2n.
// - Outputs are only active or inactive, never high impedance.
// - Sense method: 00/01 software bits, 10 latch in dead time, 11 per cycle.
// - Polarity bits and latched sense take effect in the following period.
// - At first enable the top duty registers 1,3,5 are used.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module mpo_output_stage (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [mpo_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mpo_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mpo_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [mpo_pkg::CNT_W-1:0] tb_count,
  input wire logic [mpo_pkg::CNT_W-1:0] tb_modulus,
  input wire logic tb_period_start,
  input wire logic tb_half_cycle,
  input wire logic tb_edge_aligned,
  input wire logic [mpo_pkg::NUM_PAIR-1:0] phase_current_sense_in,
  output logic [mpo_pkg::NUM_CH-1:0] pwm_out
);
  import mpo_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][DUTY_W-1:0] duty_value_reg;
    logic modulator_enable;
    logic separate_channels_option;
    logic manual_ctl;
    logic sense_method_sel_hi;
    logic sense_method_sel_lo;
    logic [NUM_PAIR-1:0] sw_current_polarity_bit;
    logic [DT_W-1:0] dead_count;
    logic dead_locked;
    logic [NUM_CH-1:0] manual_output_bit;
    logic [NUM_PAIR-1:0] sense_meta;
    logic [NUM_PAIR-1:0] sense_sync;
    logic [NUM_PAIR-1:0] sense_lat;
    logic [NUM_PAIR-1:0] pair_sel;
    logic [NUM_PAIR-1:0] dt_in_prev;
    logic [NUM_PAIR-1:0][DT_W-1:0] dt_cnt;
    logic enable_prev;
    logic [NUM_CH-1:0] out;
    logic [DATA_W-1:0] rdata;
  } mpo_state_s;

  mpo_state_s st_r;
  mpo_state_s st_nxt;
  logic [NUM_CH-1:0] gen;
  logic [NUM_PAIR-1:0] dt_in;
  logic [1:0] method;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Signed 16-bit value clamped into the 12-bit counter range
  function automatic logic [CNT_W-1:0] mpo_sat(input logic [DUTY_W-1:0] v);
    if (v[DUTY_W-1]) begin
      mpo_sat = DUTY_SAT_MIN;
    end else if (v[DUTY_W-2:CNT_W] != '0) begin
      mpo_sat = DUTY_SAT_MAX;
    end else begin
      mpo_sat = v[CNT_W-1:0];
    end
  endfunction

  // Compare against the counter with full-period corners
  function automatic logic mpo_active(input logic [CNT_W-1:0] d, input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] modulus);
    if (d == DUTY_SAT_MIN) begin
      mpo_active = 1'b0;
    end else if (d >= modulus) begin
      mpo_active = 1'b1;
    end else begin
      mpo_active = (cnt < d);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_nxt = st_r;
    method = {st_r.sense_method_sel_hi, st_r.sense_method_sel_lo};

    // Pin synchroniser; only the second stage is read below
    st_nxt.sense_meta = phase_current_sense_in;
    st_nxt.sense_sync = st_r.sense_meta;
    st_nxt.enable_prev = st_r.modulator_enable;

    // Generator outputs; pair selection only matters when paired
    for (int i = 0; i < NUM_CH; i++) begin
      gen[i] = st_r.modulator_enable &&
               mpo_active(mpo_sat(st_r.duty_value_reg[i]), tb_count, tb_modulus);
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      // Top channel of a pair runs on the chosen odd or even register
      if (!st_r.separate_channels_option) begin
        gen[2*p] = st_r.modulator_enable &&
                   mpo_active(mpo_sat(st_r.duty_value_reg[2*p + int'(st_r.pair_sel[p])]),
                              tb_count, tb_modulus);
      end
    end

    // Dead-time generator inputs
    for (int p = 0; p < NUM_PAIR; p++) begin
      dt_in[p] = st_r.manual_ctl ? st_r.manual_output_bit[2*p] : gen[2*p];
    end

    // Dead-time counters; the count is in clocks, never prescaled cycles
    for (int p = 0; p < NUM_PAIR; p++) begin
      st_nxt.dt_in_prev[p] = dt_in[p];
      if (dt_in[p] != st_r.dt_in_prev[p]) begin
        st_nxt.dt_cnt[p] = st_r.dead_count;
      end else if (st_r.dt_cnt[p] != '0) begin
        st_nxt.dt_cnt[p] = st_r.dt_cnt[p] - 8'h01;
      end
    end

    // Sense latching
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (method == SENSE_DEAD && st_r.dt_cnt[p] != '0) begin
        st_nxt.sense_lat[p] = st_r.sense_sync[p];
      end else if (method == SENSE_CYCLE &&
                   (tb_edge_aligned ? tb_period_start : tb_half_cycle)) begin
        st_nxt.sense_lat[p] = st_r.sense_sync[p];
      end
    end

    // Selection is buffered and changes only at a period start or at first enable
    if (tb_period_start) begin
      st_nxt.pair_sel = (method == SENSE_SW0 || method == SENSE_SW1) ?
                        st_r.sw_current_polarity_bit : st_r.sense_lat;
    end
    if (st_r.modulator_enable && !st_r.enable_prev) begin
      // Nothing sensed yet, so start from the top registers
      st_nxt.pair_sel = '0;
      st_nxt.sense_lat = '0;
    end

    // Output stage; registered so the pins never glitch
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (st_r.separate_channels_option) begin
        st_nxt.out[2*p] = st_r.manual_ctl ? st_r.manual_output_bit[2*p] : gen[2*p];
        st_nxt.out[2*p+1] = st_r.manual_ctl ? st_r.manual_output_bit[2*p+1] : gen[2*p+1];
      end else begin
        st_nxt.out[2*p] = dt_in[p] && st_r.dt_cnt[p] == '0 &&
                          dt_in[p] == st_r.dt_in_prev[p];
        st_nxt.out[2*p+1] = !dt_in[p] && st_r.dt_cnt[p] == '0 &&
                            dt_in[p] == st_r.dt_in_prev[p] &&
                            (st_r.manual_ctl ? st_r.manual_output_bit[2*p+1]
                                             : st_r.modulator_enable);
      end
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr <= ADDR_DUTY6) begin
        st_nxt.duty_value_reg[reg_addr[2:0]] = reg_wdata;
      end else if (reg_addr == ADDR_CTRL) begin
        st_nxt.modulator_enable = reg_wdata[CTRL_ENABLE_BIT];
        st_nxt.separate_channels_option = reg_wdata[CTRL_SEPARATE_BIT];
        st_nxt.manual_ctl = reg_wdata[CTRL_MANUAL_BIT];
        st_nxt.sense_method_sel_lo = reg_wdata[CTRL_SENSE_LO_BIT];
        st_nxt.sense_method_sel_hi = reg_wdata[CTRL_SENSE_HI_BIT];
        st_nxt.sw_current_polarity_bit = reg_wdata[CTRL_POL_LSB +: NUM_PAIR];
      end else if (reg_addr == ADDR_DEAD && !st_r.dead_locked) begin
        // Write-once guards the drive hardware against stray software
        st_nxt.dead_count = reg_wdata[DT_W-1:0];
        st_nxt.dead_locked = 1'b1;
      end else if (reg_addr == ADDR_MANUAL) begin
        st_nxt.manual_output_bit = reg_wdata[NUM_CH-1:0];
      end
    end

    // Register reads; unmapped addresses read zero
    st_nxt.rdata = '0;
    if (reg_rd) begin
      if (reg_addr <= ADDR_DUTY6) begin
        st_nxt.rdata = st_r.duty_value_reg[reg_addr[2:0]];
      end else if (reg_addr == ADDR_CTRL) begin
        st_nxt.rdata[CTRL_ENABLE_BIT] = st_r.modulator_enable;
        st_nxt.rdata[CTRL_SEPARATE_BIT] = st_r.separate_channels_option;
        st_nxt.rdata[CTRL_MANUAL_BIT] = st_r.manual_ctl;
        st_nxt.rdata[CTRL_SENSE_LO_BIT] = st_r.sense_method_sel_lo;
        st_nxt.rdata[CTRL_SENSE_HI_BIT] = st_r.sense_method_sel_hi;
        st_nxt.rdata[CTRL_POL_LSB +: NUM_PAIR] = st_r.sw_current_polarity_bit;
      end else if (reg_addr == ADDR_DEAD) begin
        st_nxt.rdata[DT_W-1:0] = st_r.dead_count;
      end else if (reg_addr == ADDR_MANUAL) begin
        st_nxt.rdata[NUM_CH-1:0] = st_r.manual_output_bit;
      end else if (reg_addr == ADDR_STATUS) begin
        st_nxt.rdata[STAT_SEL_LSB +: NUM_PAIR] = st_r.pair_sel;
        st_nxt.rdata[STAT_LAT_LSB +: NUM_PAIR] = st_r.sense_lat;
        st_nxt.rdata[STAT_OUT_LSB +: NUM_CH] = st_r.out;
        st_nxt.rdata[STAT_LOCK_BIT] = st_r.dead_locked;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.dead_count <= DEAD_RST;
      st_r.sense_method_sel_hi <= SENSE_RST[1];
      st_r.sense_method_sel_lo <= SENSE_RST[0];
      for (int i = 0; i < NUM_CH; i++) begin
        st_r.duty_value_reg[i] <= DUTY_RST;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign pwm_out = st_r.out;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_pair_exclusive;
    @(posedge sys_clk) disable iff (rst)
    !st_r.separate_channels_option |=> !(pwm_out[0] && pwm_out[1]);
  endproperty
  a_pair_exclusive: assert property (p_pair_exclusive)
    else $error("Top and bottom of pair one active together");

  property p_nonpos_inactive;
    @(posedge sys_clk) disable iff (rst)
    (st_r.separate_channels_option && !st_r.manual_ctl &&
     (st_r.duty_value_reg[1][15] || st_r.duty_value_reg[1] == 16'h0000)) |=> !pwm_out[1];
  endproperty
  a_nonpos_inactive: assert property (p_nonpos_inactive)
    else $error("Channel two active with non-positive duty");

  property p_full_active;
    @(posedge sys_clk) disable iff (rst)
    (st_r.separate_channels_option && !st_r.manual_ctl && st_r.modulator_enable &&
     !st_r.duty_value_reg[3][15] && tb_modulus != 12'h000 &&
     mpo_sat(st_r.duty_value_reg[3]) >= tb_modulus) |=> pwm_out[3];
  endproperty
  a_full_active: assert property (p_full_active)
    else $error("Channel four not active with duty at or above modulus");

  property p_overflow_clamp;
    @(posedge sys_clk) disable iff (rst)
    (st_r.duty_value_reg[2] >= 16'h1000 && st_r.duty_value_reg[2] <= 16'h7fff)
      |-> mpo_sat(st_r.duty_value_reg[2]) == 12'hfff;
  endproperty
  a_overflow_clamp: assert property (p_overflow_clamp)
    else $error("Overflow duty not clamped to full scale");

  property p_dead_both_off;
    @(posedge sys_clk) disable iff (rst)
    (!st_r.separate_channels_option && dt_in[0] != st_r.dt_in_prev[0])
      |=> !pwm_out[0] && !pwm_out[1];
  endproperty
  a_dead_both_off: assert property (p_dead_both_off)
    else $error("Pair one not forced inactive on dead-time input edge");

  property p_dead_load;
    @(posedge sys_clk) disable iff (rst)
    (dt_in[1] != st_r.dt_in_prev[1]) |=> st_r.dt_cnt[1] == $past(st_r.dead_count);
  endproperty
  a_dead_load: assert property (p_dead_load)
    else $error("Dead-time counter not loaded with programmed value");

  property p_sel_held;
    @(posedge sys_clk) disable iff (rst)
    (!tb_period_start && !(st_r.modulator_enable && !st_r.enable_prev))
      |=> $stable(st_r.pair_sel);
  endproperty
  a_sel_held: assert property (p_sel_held)
    else $error("Pair selection changed inside a period");

  property p_sel_from_polarity;
    @(posedge sys_clk) disable iff (rst)
    (tb_period_start && !st_r.sense_method_sel_hi &&
     !(st_r.modulator_enable && !st_r.enable_prev))
      |=> st_r.pair_sel == $past(st_r.sw_current_polarity_bit);
  endproperty
  a_sel_from_polarity: assert property (p_sel_from_polarity)
    else $error("Pair selection does not follow polarity bits");

  property p_first_enable_top;
    @(posedge sys_clk) disable iff (rst)
    (st_r.modulator_enable && !st_r.enable_prev) |=> st_r.pair_sel == 3'h0;
  endproperty
  a_first_enable_top: assert property (p_first_enable_top)
    else $error("Top registers not selected at first enable");

  property p_separate_follow;
    @(posedge sys_clk) disable iff (rst)
    (st_r.separate_channels_option && !st_r.manual_ctl) |=> pwm_out[3] == $past(gen[3]);
  endproperty
  a_separate_follow: assert property (p_separate_follow)
    else $error("Separate channel four does not follow its own register");

  property p_underflow_clamp;
    @(posedge sys_clk) disable iff (rst)
    st_r.duty_value_reg[1][DUTY_W-1] |-> mpo_sat(st_r.duty_value_reg[1]) == DUTY_SAT_MIN;
  endproperty
  a_underflow_clamp: assert property (p_underflow_clamp)
    else $error("Underflow duty not clamped to zero");

  property p_separate_no_select;
    @(posedge sys_clk) disable iff (rst)
    (st_r.separate_channels_option && !st_r.manual_ctl)
      |=> pwm_out[0] == $past(st_r.modulator_enable &&
                              mpo_active(mpo_sat(st_r.duty_value_reg[0]), tb_count, tb_modulus));
  endproperty
  a_separate_no_select: assert property (p_separate_no_select)
    else $error("Separate channel one not driven from its own register");

  property p_dead_countdown;
    @(posedge sys_clk) disable iff (rst)
    (dt_in[2] == st_r.dt_in_prev[2] && st_r.dt_cnt[2] != 8'h00)
      |=> st_r.dt_cnt[2] == $past(st_r.dt_cnt[2]) - 8'h01;
  endproperty
  a_dead_countdown: assert property (p_dead_countdown)
    else $error("Dead-time counter of pair three does not count down");

  property p_manual_bottom_off;
    @(posedge sys_clk) disable iff (rst)
    (!st_r.separate_channels_option && st_r.manual_ctl && st_r.manual_output_bit[2])
      |=> !pwm_out[3];
  endproperty
  a_manual_bottom_off: assert property (p_manual_bottom_off)
    else $error("Manual bottom of pair two active while its top bit is set");

endmodule

`default_nettype wire

// ---- hw/mpo_pkg.sv ----
// Constants shared by the motor PWM output stage
package mpo_pkg;

  localparam int unsigned NUM_CH = 6;
  localparam int unsigned NUM_PAIR = 3;
  localparam int unsigned DUTY_W = 16;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned DT_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // Register offsets (word index on the register port)
  localparam logic [3:0] ADDR_DUTY1 = 4'h0;
  localparam logic [3:0] ADDR_DUTY6 = 4'h5;
  localparam logic [3:0] ADDR_CTRL = 4'h6;
  localparam logic [3:0] ADDR_DEAD = 4'h7;
  localparam logic [3:0] ADDR_MANUAL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'h9;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_SEPARATE_BIT = 1;
  localparam int unsigned CTRL_MANUAL_BIT = 2;
  localparam int unsigned CTRL_SENSE_LO_BIT = 3;
  localparam int unsigned CTRL_SENSE_HI_BIT = 4;
  localparam int unsigned CTRL_POL_LSB = 5;

  // Status register fields
  localparam int unsigned STAT_SEL_LSB = 0;
  localparam int unsigned STAT_LAT_LSB = 3;
  localparam int unsigned STAT_OUT_LSB = 6;
  localparam int unsigned STAT_LOCK_BIT = 12;

  // Reset values
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [7:0] DEAD_RST = 8'hff;
  localparam logic [1:0] SENSE_RST = 2'h0;

  // Saturation limits
  localparam logic [11:0] DUTY_SAT_MAX = 12'hfff;
  localparam logic [11:0] DUTY_SAT_MIN = 12'h000;

  // Sense method codes
  localparam logic [1:0] SENSE_SW0 = 2'h0;
  localparam logic [1:0] SENSE_SW1 = 2'h1;
  localparam logic [1:0] SENSE_DEAD = 2'h2;
  localparam logic [1:0] SENSE_CYCLE = 2'h3;

endpackage

// ---- verif/mpo_phase_model.sv ----
// Behavioural model of the phase current sense circuitry beside the gate drivers
`timescale 1ns/10ps
`default_nettype none

module mpo_phase_model (
  input wire logic sys_clk,
  input wire logic [2:0] current_neg,
  output logic [2:0] phase_current_sense_in
);
  initial phase_current_sense_in = 3'h0;
  // Pins settle a few ns after the edge; the block must synchronise them itself
  always @(posedge sys_clk) begin
    phase_current_sense_in <= #3 current_neg;
  end
endmodule

`default_nettype wire

// ---- verif/tb_mpo_output_stage.sv ----
// Self-checking testbench for the motor PWM output stage
`timescale 1ns/10ps
`default_nettype none

module tb_mpo_output_stage;
  import mpo_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [CNT_W-1:0] tb_count = 12'h000;
  logic [CNT_W-1:0] tb_modulus = 12'h010;
  logic [CNT_W-1:0] cnt_nxt;
  logic tb_period_start = 1'b0;
  logic tb_half_cycle = 1'b0;
  logic tb_edge_aligned = 1'b1;
  logic [NUM_PAIR-1:0] phase_current_sense_in;
  logic [NUM_PAIR-1:0] current_neg = 3'h0;
  logic [NUM_CH-1:0] pwm_out;
  int miscompares = 0;
  int n_compared = 0;

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Up-only timebase, modulus 16, period start and half-cycle pulses
  always_comb cnt_nxt = (tb_count == tb_modulus - 12'h001) ? 12'h000 : tb_count + 12'h001;
  always @(posedge sys_clk) begin
    tb_count <= rst ? 12'h000 : cnt_nxt;
    tb_period_start <= !rst && (cnt_nxt == 12'h000);
    tb_half_cycle <= !rst && (cnt_nxt == (tb_modulus >> 1));
  end

  mpo_output_stage dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tb_count(tb_count), .tb_modulus(tb_modulus), .tb_period_start(tb_period_start),
    .tb_half_cycle(tb_half_cycle), .tb_edge_aligned(tb_edge_aligned),
    .phase_current_sense_in(phase_current_sense_in), .pwm_out(pwm_out));

  mpo_phase_model model (.sys_clk(sys_clk), .current_neg(current_neg),
    .phase_current_sense_in(phase_current_sense_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus tasks are entered just after a rising edge and leave on one
  // A write lets one idle edge pass, so back-to-back writes never reassign the strobe at once
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                    input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    check(d & mask, exp);
    @(posedge sys_clk);
  endtask

  task automatic duties(input logic [NUM_CH-1:0][DATA_W-1:0] v);
    for (int c = 0; c < NUM_CH; c++) begin
      wr(ADDR_DUTY1 + 4'(c), v[c]);
    end
  endtask

  // Counts active cycles per output over two periods; start phase does not matter
  task automatic measure(input logic [NUM_CH-1:0][7:0] exp, input logic comp);
    logic [7:0] act [NUM_CH];
    logic [7:0] both;
    act = '{default: 8'h00};
    both = 8'h00;
    repeat (32) begin
      @(posedge sys_clk);
      #1;
      for (int c = 0; c < NUM_CH; c++) act[c] += 8'(pwm_out[c]);
      both += 8'((pwm_out[0] & pwm_out[1]) | (pwm_out[2] & pwm_out[3]) | (pwm_out[4] & pwm_out[5]));
    end
    for (int c = 0; c < NUM_CH; c++) check(16'(act[c]), 16'(exp[c]));
    if (comp) check(16'(both), 16'h0000);
    @(posedge sys_clk);
  endtask

  // Bounded wait for a timebase value, so writes land clear of a period start
  task automatic sync_to(input logic [CNT_W-1:0] v);
    int i;
    i = 0;
    while (tb_count !== v && i < 64) begin
      @(posedge sys_clk);
      i++;
    end
    if (i == 64) begin
      miscompares++;
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc(ADDR_DEAD, {8'h00, DEAD_RST}, 16'hffff);
    rc(ADDR_STATUS, 16'h0000, 16'hffff);
    rc(4'hf, 16'h0000, 16'hffff);
    wr(ADDR_DEAD, 16'h0002);
    wr(ADDR_DEAD, 16'h0005);
    rc(ADDR_DEAD, 16'h0002, 16'hffff);
    rc(ADDR_STATUS, 16'h1000, 16'h1000);
    // Separate channels: saturation at both ends, no dead time
    duties({16'hffff, 16'h7fff, 16'h0010, 16'h1000, 16'h8000, 16'h0008});
    // Polarity bits set too: separate mode must ignore them
    wr(ADDR_CTRL, 16'h00e3);
    repeat (20) @(posedge sys_clk);
    measure({8'd0, 8'd32, 8'd32, 8'd32, 8'd0, 8'd16}, 1'b0);
    // Complementary pairs, odd registers, dead time of 2 plus one settle cycle
    duties({16'h000c, 16'h0004, 16'h000c, 16'h0004, 16'h000c, 16'h0004});
    wr(ADDR_CTRL, 16'h0001);
    repeat (20) @(posedge sys_clk);
    measure({8'd18, 8'd2, 8'd18, 8'd2, 8'd18, 8'd2}, 1'b1);
    // Polarity bits for pairs 1 and 3; mid-period change waits for next period
    sync_to(12'h003);
    wr(ADDR_CTRL, 16'h00a1);
    rc(ADDR_STATUS, 16'h0000, 16'h0007);
    repeat (20) @(posedge sys_clk);
    rc(ADDR_STATUS, 16'h0005, 16'h0007);
    measure({8'd2, 8'd18, 8'd18, 8'd2, 8'd2, 8'd18}, 1'b1);
    // Sensing once per cycle, edge-aligned
    current_neg <= 3'b010;
    wr(ADDR_CTRL, 16'h0019);
    repeat (40) @(posedge sys_clk);
    rc(ADDR_STATUS, 16'h0012, 16'h003f);
    // Sensing during dead time
    current_neg <= 3'b100;
    wr(ADDR_CTRL, 16'h0011);
    repeat (40) @(posedge sys_clk);
    rc(ADDR_STATUS, 16'h0024, 16'h003f);
    // Re-enable with sensing selected starts from the odd registers
    wr(ADDR_CTRL, 16'h0018);
    sync_to(12'h003);
    wr(ADDR_CTRL, 16'h0019);
    rc(ADDR_STATUS, 16'h0000, 16'h003f);
    // Centre-aligned sensing latches at the half cycle; method 01 uses polarity bits
    tb_edge_aligned <= 1'b0;
    current_neg <= 3'b001;
    repeat (40) @(posedge sys_clk);
    rc(ADDR_STATUS, 16'h0009, 16'h003f);
    wr(ADDR_CTRL, 16'h0049);
    repeat (20) @(posedge sys_clk);
    rc(ADDR_STATUS, 16'h000a, 16'h003f);
    // Manual control: paired, odd bits feed dead time and even bits gate the bottoms; separate, bits drive the outputs directly
    wr(ADDR_MANUAL, 16'h000e);
    wr(ADDR_CTRL, 16'h0005);
    repeat (10) @(posedge sys_clk);
    check({10'h000, pwm_out}, 16'h0006);
    wr(ADDR_CTRL, 16'h0007);
    wr(ADDR_MANUAL, 16'h002a);
    repeat (4) @(posedge sys_clk);
    check({10'h000, pwm_out}, 16'h002a);
    results();
  end
endmodule

`default_nettype wire
